// *** bench/ddoa_door_drive_checker.sv ***
// ddoa_door_drive_checker: concurrent checks on the drive outputs.
// assumes default opening parameters and a tick of at least nine cycles.
`timescale 1ns/1ps
module ddoa_door_drive_checker
  import ddoa_pkg::*;
#(
  parameter int TICK_LEN = 20
)
(
  input wire logic          clk,
  input wire logic          rst_n,
  input wire logic          serviceButtonA,
  input wire logic          disableIn,
  input wire logic [DW-1:0] doorPos,
  input wire logic [DW-1:0] motorSpeed,
  input wire logic          motorDirClose,
  input wire logic          motorEnergized,
  input wire logic [DW-1:0] forceLimit
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_MAX_SPEED: assert property (motorSpeed <= 16'h0100)
    else $error("speed above maximum");
  AST_ACCEL: assert property (!motorDirClose && motorSpeed > $past(motorSpeed) |->
    motorSpeed - $past(motorSpeed) <= 16'h0008) else $error("acceleration step too large");
  // reversal may brake harder than the plain ramp, never beyond it
  AST_DECEL: assert property (!motorDirClose && motorSpeed < $past(motorSpeed) |->
    $past(motorSpeed) - motorSpeed <= 16'h0010) else $error("deceleration step too large");
  AST_SLOW_START: assert property (motorEnergized && !motorDirClose && doorPos < 16'h0020 |->
    motorSpeed <= 16'h0010) else $error("too fast near closed end");
  AST_STOP_RESP: assert property ((serviceButtonA || disableIn) && motorSpeed != 16'h0000 |->
    ##[1:120] motorSpeed < $past(motorSpeed)) else $error("no braking after stop order");
  AST_FREEWHEEL: assert property (disableIn && motorSpeed == 16'h0000 && $past(motorSpeed) != 16'h0000 |->
    ##[0:60] !motorEnergized) else $error("motor not released after special stop");
  AST_OPEN_FORCE: assert property (!motorDirClose && motorSpeed > $past(motorSpeed) |->
    forceLimit == 16'h0200) else $error("opening force limit wrong");
  AST_TICK_HOLD: assert property ($changed(motorSpeed) |=> $stable(motorSpeed) [*8])
    else $error("speed changed between ticks");
  cover property (!motorEnergized ##1 motorEnergized);
  cover property (doorPos == 16'h1000 && !motorDirClose);
  cover property (disableIn && motorSpeed != 16'h0000);
endmodule
bind ddoa_door_drive ddoa_door_drive_checker #(.TICK_LEN(TICK_LEN)) chk_u (.clk(clk), .rst_n(rst_n),
  .serviceButtonA(serviceButtonA), .disableIn(disableIn), .doorPos(doorPos), .motorSpeed(motorSpeed),
  .motorDirClose(motorDirClose), .motorEnergized(motorEnergized), .forceLimit(forceLimit));

// *** bench/ddoa_door_drive_tb.sv ***
// ddoa_door_drive_tb: source priority, opening hold, special stop and cyclic test.
// assumes the door model closes the position loop and a 20-cycle tick.
`timescale 1ns/1ps
module ddoa_door_drive_tb
  import ddoa_pkg::*;
();
  localparam int TL = 20;
  logic          clk = 1'h0;
  logic          rst_n = 1'h0;
  logic [AW-1:0] regAddr = 4'h0;
  logic [DW-1:0] regWrData = 16'h0000;
  logic          regWr = 1'h0;
  logic          regRd = 1'h0;
  logic          serviceButtonA = 1'h0;
  logic          serviceButtonOpen = 1'h0;
  logic          serviceButtonClose = 1'h0;
  logic [3:0]    remoteDoorCommandWord = 4'h0;
  logic [3:0]    doorCommandWord = 4'h0;
  logic          disableIn = 1'h0;
  logic [DW-1:0] doorPos, motorSpeed, forceLimit, regRdData, rd;
  logic          motorDirClose, motorEnergized, unlockOut;
  logic          sawUnlock = 1'h0;
  int            n_errors = 0;
  int            checks_done = 0;
  int            i;
  // rows: {buttons A/open/close, terminal valid+cmd, remote word, local word, expected winner}
  logic [17:0]   arb [9] = '{18'h0010A, 18'h00193, 18'h00124, 18'h00289, 18'h04821,
                             18'h15021, 18'h18002, 18'h28004, 18'h00000};
  ddoa_door_drive #(.TICK_LEN(TL)) dut_u (.*);
  ddoa_door_model #(.TICK_LEN(TL)) door_u (.*);
  always #5 clk = ~clk;
  always @(posedge clk)
    if (unlockOut === 1'h1)
      sawUnlock <= 1'h1;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [DW-1:0] got, input logic [DW-1:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tmo(input int n);
    if (n == 0)
    begin
      n_errors++;
      $display("[FAIL] wait expected done seen timeout");
      stop_test();
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'h1;
    @(posedge clk);
    regWr <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rdr(input logic [AW-1:0] a);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk);
    regRd <= 1'h0;
    #1 rd = regRdData;
    @(posedge clk);
  endtask
  task automatic tk(input int n);
    repeat (n * TL) @(posedge clk);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rdr(REG_MAX_SPEED);
    chk("max speed", rd, RST_MAX_SPEED);
    rdr(4'hF);
    chk("unmapped", rd, 16'h0000);
    wr(REG_REVERSAL, 16'h0010);
    for (i = 0; i < 9; i++)
    begin
      {serviceButtonA, serviceButtonOpen, serviceButtonClose} <= arb[i][17:15];
      wr(REG_CTRL, {10'h000, arb[i][13:11], 1'h0, arb[i][14], 1'h0});
      remoteDoorCommandWord <= arb[i][10:7];
      doorCommandWord <= arb[i][6:3];
      tk(3);
      rdr(REG_STATUS);
      chk("winner", {13'h0000, rd[2:0]}, {13'h0000, arb[i][2:0]});
    end
    $display("test arbitration done");
    doorCommandWord <= 4'h2;
    for (i = 8000; i > 0 && doorPos !== 16'h0000; i--)
      @(posedge clk);
    tmo(i);
    doorCommandWord <= 4'h1;
    for (i = 4000; i > 0 && doorPos !== 16'h1000; i--)
      @(posedge clk);
    tmo(i);
    tk(3);
    rdr(REG_STATUS);
    chk("hold state", {8'h00, rd[15:8]}, 16'h0010);
    chk("hold energized", {15'h0000, motorEnergized}, 16'h0001);
    for (i = 1000; i > 0 && motorSpeed !== 16'h0000; i--)
      @(posedge clk);
    tmo(i);
    tk(STANDSTILL_TICKS - 2);
    chk("standstill force", forceLimit, RST_STATIC_FORCE);
    tk(4);
    chk("idle torque", forceLimit, RST_IDLE_TORQUE);
    $display("test open done");
    doorCommandWord <= 4'h2;
    for (i = 400; i > 0 && motorSpeed === 16'h0000; i--)
      @(posedge clk);
    tmo(i);
    tk(2);
    disableIn <= 1'h1;
    doorCommandWord <= 4'h0;
    for (i = 400; i > 0 && motorSpeed !== 16'h0000; i--)
      @(posedge clk);
    tmo(i);
    // freewheel lasts one tick once the stop order is gone
    tk(1);
    rdr(REG_STATUS);
    chk("free state", {8'h00, rd[15:8]}, 16'h0040);
    for (i = 400; i > 0 && motorEnergized !== 1'h0; i--)
      @(posedge clk);
    tmo(i);
    chk("free speed", motorSpeed, 16'h0000);
    disableIn <= 1'h0;
    $display("test disable done");
    wr(REG_CYC_TARGET, 16'h0001);
    wr(REG_CTRL, 16'h0001);
    rd = 16'h0000;
    for (i = 1500; i > 0 && rd !== 16'h0001; i--)
    begin
      tk(1);
      rdr(REG_CYC_DONE);
    end
    tmo(i);
    chk("unlock seen", {15'h0000, sawUnlock}, 16'h0001);
    wr(REG_CTRL, 16'h0000);
    wr(REG_CYC_DONE, 16'h0000);
    rdr(REG_CYC_DONE);
    chk("cycles cleared", rd, 16'h0000);
    $display("test cyclic done");
    stop_test();
  end
endmodule

// *** bench/ddoa_door_model.sv ***
// ddoa_door_model: door mechanism moved by the drive's speed setpoint.
// assumes one position step per tick, clamped at both end stops.
`timescale 1ns/1ps
module ddoa_door_model
  import ddoa_pkg::*;
#(
  parameter int TICK_LEN = 20
)
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [DW-1:0] motorSpeed,
  input  wire logic          motorDirClose,
  output logic      [DW-1:0] doorPos
);
  int cnt;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 0;
      doorPos <= 16'h0000;
    end
    else if (cnt == TICK_LEN - 1)
    begin
      cnt <= 0;
      if (motorDirClose)
        doorPos <= (doorPos > motorSpeed) ? doorPos - motorSpeed : 16'h0000;
      else
        doorPos <= (doorPos + motorSpeed > 16'h1000) ? 16'h1000 : doorPos + motorSpeed;
    end
    else
      cnt <= cnt + 1;
  end
endmodule

// *** src/ddoa_arbiter.sv ***
// ddoa_arbiter: picks the winning door command among all drive order sources.
// assumes all inputs already synchronous; purely combinational.
`timescale 1ns/1ps
module ddoa_arbiter
  import ddoa_pkg::*;
(
  input  wire logic       btnStop,
  input  wire logic       btnOpen,
  input  wire logic       btnClose,
  input  wire logic       termValid,
  input  wire ddoa_cmd_t  termCmd,
  input  wire logic       termSpecial,
  input  wire logic [3:0] remoteWord,
  input  wire logic [3:0] localWord,
  output ddoa_cmd_t       winCmd,
  output logic            winSpecial
);
  ddoa_cmd_t btnCmd;
  ddoa_cmd_t remCmd;
  ddoa_cmd_t locCmd;

  always_comb
  begin
    remCmd = ddoa_word_cmd(remoteWord[2:0]);
    locCmd = ddoa_word_cmd(localWord[2:0]);
    btnCmd = btnStop ? CMD_STOP : btnClose ? CMD_CLOSE : btnOpen ? CMD_OPEN : CMD_NONE;
    if (btnCmd != CMD_NONE)
    begin
      winCmd = btnCmd;
      winSpecial = 1'b0;
    end
    else if (termValid && termCmd != CMD_NONE)
    begin
      winCmd = termCmd;
      winSpecial = termSpecial;
    end
    else if (remCmd >= locCmd)
    begin
      winCmd = remCmd;
      winSpecial = remoteWord[WORD_SPECIAL] && remCmd == CMD_STOP;
    end
    else
    begin
      winCmd = locCmd;
      winSpecial = localWord[WORD_SPECIAL] && locCmd == CMD_STOP;
    end
  end
endmodule

// *** src/ddoa_door_drive.sv ***
// ddoa_door_drive: door drive order arbitration and opening speed/force profile.
// assumes inputs synchronous to clk; register port with read data one cycle after the strobe.
// Summary of operation
// - the highest-ranked source present wins; lower sources are discarded.
// - the three board service buttons rank above every other source.
// - service terminal or PC tool commands rank second, above command words.
// - remote and local command words share lowest rank; higher command wins.
// - stop ranks highest; with special extension, ramp down then freewheel deenergized.
// - learn run ranks second and is interrupted by a higher command.
// - close beats open; both beat deenergize, the idle inactive state.
// - a new drive order changes motor current within 60 ms.
// - disable input during travel forces a special stop.
// - before moving, snapshot the profile parameter set of that direction; learn runs go from S_IDLE to S_LEARN without a snapshot.
// - during motion the speed setpoint follows door position on the profile; closing and learn runs use slowStart instead.
// - force limit by position while moving, by elapsed time at standstill; the code holds staticForce throughout motion.
// - near the closed end, open at slow start speed to release interlock.
// - within creep distance before open end, limit to slow end speed.
// - opening speed never exceeds the configured maximum.
// - opening acceleration is capped by the configured acceleration ramp.
// - opening deceleration is capped by the configured deceleration ramp, or by the reversal ramp when a close order reverses it.
// - open command held at open end keeps the idle torque applied.
// - while opening, force is limited to the static opening force limit.
// - cyclic test cycles the door, unlocks before opening, counts cycles.
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module ddoa_door_drive
  import ddoa_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [AW-1:0] regAddr,
  input  wire logic [DW-1:0] regWrData,
  input  wire logic          regWr,
  input  wire logic          regRd,
  output logic      [DW-1:0] regRdData,
  input  wire logic          serviceButtonA,
  input  wire logic          serviceButtonOpen,
  input  wire logic          serviceButtonClose,
  input  wire logic    [3:0] remoteDoorCommandWord,
  input  wire logic    [3:0] doorCommandWord,
  input  wire logic          disableIn,
  input  wire logic [DW-1:0] doorPos,
  output logic      [DW-1:0] motorSpeed,
  output logic               motorDirClose,
  output logic               motorEnergized,
  output logic      [DW-1:0] forceLimit,
  output logic               unlockOut
);

  typedef enum logic [7:0]
  {
    S_IDLE  = 8'h01,
    S_PREP  = 8'h02,
    S_OPEN  = 8'h04,
    S_CLOSE = 8'h08,
    S_HOLD  = 8'h10,
    S_STOP  = 8'h20,
    S_FREE  = 8'h40,
    S_LEARN = 8'h80
  } ddoa_state_t;

  typedef enum logic [2:0]
  {
    CY_UNLOCK = 3'h1,
    CY_OPEN   = 3'h2,
    CY_CLOSE  = 3'h4
  } ddoa_cyc_t;

  ddoa_prof_if prof ();

  ddoa_state_t   state;
  ddoa_cyc_t     cycPhase;
  ddoa_cmd_t     winCmd;
  ddoa_cmd_t     activeCmd;
  ddoa_cmd_t     termCmd;
  logic          winSpecial;
  logic          activeSpecial;
  logic          termValid;
  logic          revPending;
  logic          prepClose;
  logic [DW-1:0] ctrl;
  logic [DW-1:0] cutterDist;
  logic [DW-1:0] slowStart;
  logic [DW-1:0] creepDist;
  logic [DW-1:0] slowEnd;
  logic [DW-1:0] maxSpeed;
  logic [DW-1:0] accelRamp;
  logic [DW-1:0] decelRamp;
  logic [DW-1:0] reversalRamp;
  logic [DW-1:0] idleTorque;
  logic [DW-1:0] staticForce;
  logic [DW-1:0] doorWidth;
  logic [DW-1:0] cycTarget;
  logic [DW-1:0] cycDone;
  logic [DW-1:0] snapAccel;
  logic [DW-1:0] snapDecel;
  logic [DW-1:0] snapReversal;
  logic [DW-1:0] targetSpeed;
  logic [DW-1:0] stepDown;
  logic [DW-1:0] standTicks;
  logic [DW-1:0] unlockTicks;
  logic [31:0]   tickCnt;
  logic          tick;
  logic          clrDone;
  logic          cycActive;
  logic          atOpen;
  logic          atClosed;
  logic          moving;

  assign atOpen    = doorPos >= doorWidth;
  assign atClosed  = doorPos == '0;
  assign moving    = motorSpeed != '0;
  assign cycActive = ctrl[CTRL_CYC_EN] && cycDone < cycTarget;
  assign clrDone   = regWr && regAddr == REG_CYC_DONE;

  // register writes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl         <= '0;
      cutterDist   <= RST_CUTTER_DIST;
      slowStart    <= RST_SLOW_START;
      creepDist    <= RST_CREEP_DIST;
      slowEnd      <= RST_SLOW_END;
      maxSpeed     <= RST_MAX_SPEED;
      accelRamp    <= RST_ACCEL_RAMP;
      decelRamp    <= RST_DECEL_RAMP;
      reversalRamp <= RST_REVERSAL;
      idleTorque   <= RST_IDLE_TORQUE;
      staticForce  <= RST_STATIC_FORCE;
      doorWidth    <= RST_DOOR_WIDTH;
      cycTarget    <= RST_CYC_TARGET;
    end
    else if (regWr)
    begin
      unique case (regAddr)
        REG_CTRL:         ctrl         <= regWrData;
        REG_CUTTER_DIST:  cutterDist   <= regWrData;
        REG_SLOW_START:   slowStart    <= regWrData;
        REG_CREEP_DIST:   creepDist    <= regWrData;
        REG_SLOW_END:     slowEnd      <= regWrData;
        REG_MAX_SPEED:    maxSpeed     <= regWrData;
        REG_ACCEL_RAMP:   accelRamp    <= regWrData;
        REG_DECEL_RAMP:   decelRamp    <= regWrData;
        REG_REVERSAL:     reversalRamp <= regWrData;
        REG_IDLE_TORQUE:  idleTorque   <= regWrData;
        REG_STATIC_FORCE: staticForce  <= regWrData;
        REG_DOOR_WIDTH:   doorWidth    <= regWrData;
        REG_CYC_TARGET:   cycTarget    <= regWrData;
        default:          ;
      endcase
    end
  end

  // register reads; unmapped words read zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      regRdData <= '0;
    else if (regRd)
    begin
      unique case (regAddr)
        REG_CTRL:         regRdData <= ctrl;
        REG_STATUS:       regRdData <= {state, cycActive, revPending, activeSpecial, motorDirClose, 1'b0, activeCmd};
        REG_CUTTER_DIST:  regRdData <= cutterDist;
        REG_SLOW_START:   regRdData <= slowStart;
        REG_CREEP_DIST:   regRdData <= creepDist;
        REG_SLOW_END:     regRdData <= slowEnd;
        REG_MAX_SPEED:    regRdData <= maxSpeed;
        REG_ACCEL_RAMP:   regRdData <= accelRamp;
        REG_DECEL_RAMP:   regRdData <= decelRamp;
        REG_REVERSAL:     regRdData <= reversalRamp;
        REG_IDLE_TORQUE:  regRdData <= idleTorque;
        REG_STATIC_FORCE: regRdData <= staticForce;
        REG_DOOR_WIDTH:   regRdData <= doorWidth;
        REG_CYC_TARGET:   regRdData <= cycTarget;
        REG_CYC_DONE:     regRdData <= cycDone;
        default:          regRdData <= '0;
      endcase
    end
  end

  // control update tick; one tick is far below the response bound
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tickCnt <= '0;
      tick    <= 1'b0;
    end
    else if (tickCnt >= 32'(TICK_LEN - 1))
    begin
      tickCnt <= '0;
      tick    <= 1'b1;
    end
    else
    begin
      tickCnt <= tickCnt + 32'h1;
      tick    <= 1'b0;
    end
  end

  // cyclic test rides on the terminal rank
  always_comb
  begin
    termValid = ctrl[CTRL_TERM_VALID] || cycActive;
    if (cycActive)
      termCmd = (cycPhase == CY_OPEN) ? CMD_OPEN : (cycPhase == CY_CLOSE) ? CMD_CLOSE : CMD_NONE;
    else
      termCmd = ddoa_word_cmd(ctrl[CTRL_TERM_CMD_LSB +: 3]);
  end

  ddoa_arbiter u_arb
  (
    .btnStop     (serviceButtonA),
    .btnOpen     (serviceButtonOpen),
    .btnClose    (serviceButtonClose),
    .termValid   (termValid),
    .termCmd     (termCmd),
    .termSpecial (ctrl[CTRL_TERM_SPECIAL] && !cycActive),
    .remoteWord  (remoteDoorCommandWord),
    .localWord   (doorCommandWord),
    .winCmd      (winCmd),
    .winSpecial  (winSpecial)
  );

  // latched order, refreshed every tick
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      activeCmd     <= CMD_NONE;
      activeSpecial <= 1'b0;
    end
    else if (tick)
    begin
      if (disableIn && moving)
      begin
        activeCmd     <= CMD_STOP;
        activeSpecial <= 1'b1;
      end
      else
      begin
        activeCmd     <= winCmd;
        activeSpecial <= winSpecial;
      end
    end
  end

  // drive sequencing
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state         <= S_IDLE;
      revPending    <= 1'b0;
      prepClose     <= 1'b0;
      motorDirClose <= 1'b0;
      snapAccel     <= '0;
      snapDecel     <= '0;
      snapReversal  <= '0;
    end
    else if (tick)
    begin
      unique case (state)
        S_IDLE:
          if (activeCmd == CMD_STOP)
            state <= S_STOP;
          else if (activeCmd == CMD_LEARN)
            state <= S_LEARN;
          else if (activeCmd == CMD_CLOSE && !atClosed)
          begin
            prepClose <= 1'b1;
            state     <= S_PREP;
          end
          else if (activeCmd == CMD_OPEN)
          begin
            prepClose <= 1'b0;
            state     <= atOpen ? S_HOLD : S_PREP;
          end
        S_PREP:
        begin
          snapAccel     <= accelRamp;
          snapDecel     <= decelRamp;
          snapReversal  <= reversalRamp;
          motorDirClose <= prepClose;
          state         <= prepClose ? S_CLOSE : S_OPEN;
        end
        S_OPEN:
          if (activeCmd == CMD_STOP || activeCmd == CMD_LEARN || activeCmd == CMD_NONE)
            state <= S_STOP;
          else if (activeCmd == CMD_CLOSE)
          begin
            revPending <= 1'b1;
            prepClose  <= 1'b1;
            state      <= S_STOP;
          end
          else if (atOpen)
            state <= S_HOLD;
        S_CLOSE:
          if (activeCmd != CMD_CLOSE)
          begin
            revPending <= activeCmd == CMD_OPEN;
            prepClose  <= 1'b0;
            state      <= S_STOP;
          end
          else if (atClosed)
            state <= S_IDLE;
        S_HOLD:
          if (activeCmd != CMD_OPEN)
            state <= S_IDLE;
        S_STOP:
          if (!moving)
          begin
            revPending <= 1'b0;
            if (activeSpecial)
              state <= S_FREE;
            else if (revPending)
              state <= S_PREP;
            else if (activeCmd != CMD_STOP)
              state <= S_IDLE;
          end
        S_FREE:
          if (activeCmd != CMD_STOP)
            state <= S_IDLE;
        S_LEARN:
          if (activeCmd != CMD_LEARN || atOpen)
            state <= S_STOP;
      endcase
    end
  end

  // parameter snapshot feeds the profile generator
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prof.cutterDist   <= '0;
      prof.slowStartSpd <= '0;
      prof.creepDist    <= '0;
      prof.slowEndSpd   <= '0;
      prof.maxSpd       <= '0;
      prof.doorWidth    <= '0;
    end
    else if (tick && state == S_PREP && !prepClose)
    begin
      prof.cutterDist   <= cutterDist;
      prof.slowStartSpd <= slowStart;
      prof.creepDist    <= creepDist;
      prof.slowEndSpd   <= slowEnd;
      prof.maxSpd       <= maxSpeed;
      prof.doorWidth    <= doorWidth;
    end
  end

  assign prof.pos = doorPos;

  ddoa_open_profile u_prof
  (
    .prof (prof)
  );

  always_comb
  begin
    unique case (state)
      S_OPEN:  targetSpeed = prof.target;
      S_CLOSE: targetSpeed = atClosed ? '0 : slowStart;
      S_LEARN: targetSpeed = slowStart;
      default: targetSpeed = '0;
    endcase
    // reversal ramp assumed not below the decel ramp
    stepDown = (state == S_STOP && revPending) ? snapReversal : snapDecel;
  end

  // speed ramp toward the setpoint
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      motorSpeed <= '0;
    else if (tick)
    begin
      if (motorSpeed < targetSpeed)
        motorSpeed <= (targetSpeed - motorSpeed > snapAccel) ? motorSpeed + snapAccel : targetSpeed;
      else if (motorSpeed > targetSpeed)
        motorSpeed <= (motorSpeed - targetSpeed > stepDown) ? motorSpeed - stepDown : targetSpeed;
    end
  end

  // force limit: staticForce in motion, by time at standstill
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      forceLimit     <= '0;
      standTicks     <= '0;
      motorEnergized <= 1'b0;
    end
    else if (tick)
    begin
      motorEnergized <= !(state == S_IDLE || state == S_FREE);
      if (state == S_OPEN || state == S_CLOSE || state == S_LEARN || moving)
      begin
        standTicks <= '0;
        forceLimit <= staticForce;
      end
      else
      begin
        if (standTicks < DW'(STANDSTILL_TICKS))
          standTicks <= standTicks + 16'h0001;
        if (state == S_IDLE || state == S_FREE)
          forceLimit <= '0;
        else if (standTicks < DW'(STANDSTILL_TICKS))
          forceLimit <= staticForce;
        else if (state == S_HOLD)
          forceLimit <= idleTorque;
        else
          forceLimit <= staticForce;
      end
    end
  end

  // cyclic test sequencing; counting beats a clearing write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cycPhase    <= CY_UNLOCK;
      cycDone     <= '0;
      unlockTicks <= '0;
      unlockOut   <= 1'b0;
    end
    else
    begin
      if (clrDone && !(tick && cycActive && cycPhase == CY_CLOSE && state == S_IDLE && atClosed))
        cycDone <= '0;
      if (!cycActive)
      begin
        cycPhase    <= CY_UNLOCK;
        unlockTicks <= '0;
        unlockOut   <= 1'b0;
      end
      else if (tick)
      begin
        unique case (cycPhase)
          CY_UNLOCK:
          begin
            unlockOut <= 1'b1;
            if (unlockTicks >= DW'(UNLOCK_TICKS))
            begin
              unlockOut <= 1'b0;
              cycPhase  <= CY_OPEN;
            end
            else
              unlockTicks <= unlockTicks + 16'h0001;
          end
          CY_OPEN:
            if (state == S_HOLD)
              cycPhase <= CY_CLOSE;
          CY_CLOSE:
            if (state == S_IDLE && atClosed)
            begin
              cycDone     <= cycDone + 16'h0001;
              unlockTicks <= '0;
              cycPhase    <= CY_UNLOCK;
            end
        endcase
      end
    end
  end

endmodule

// *** src/ddoa_open_profile.sv ***
// ddoa_open_profile: speed setpoint along the opening profile from door position.
// assumes position 0 is the closed end and doorWidth the open end.
`timescale 1ns/1ps
module ddoa_open_profile
  import ddoa_pkg::*;
(
  ddoa_prof_if.gen prof
);
  logic [DW-1:0] toGo;
  logic [DW-1:0] raw;

  always_comb
  begin
    toGo = (prof.doorWidth > prof.pos) ? prof.doorWidth - prof.pos : '0;
    if (toGo == '0)
      raw = '0;
    else if (prof.pos < prof.cutterDist)
      raw = prof.slowStartSpd;
    else if (toGo <= prof.creepDist)
      raw = prof.slowEndSpd;
    else
      raw = prof.maxSpd;
    prof.target = (raw > prof.maxSpd) ? prof.maxSpd : raw;
  end
endmodule

// *** src/ddoa_pkg.sv ***
// ddoa_pkg: shared constants and types of the door drive order arbiter and opening profile.
// assumes a single 100 MHz controller clock and 16-bit register data.
package ddoa_pkg;

  localparam int DW = 16;
  localparam int AW = 4;

  // door command codes; a higher code is a higher-ranked command
  typedef enum logic [2:0]
  {
    CMD_NONE  = 3'h0,
    CMD_OPEN  = 3'h1,
    CMD_CLOSE = 3'h2,
    CMD_LEARN = 3'h3,
    CMD_STOP  = 3'h4
  } ddoa_cmd_t;

  // register word indices
  localparam logic [AW-1:0] REG_CTRL         = 4'h0;
  localparam logic [AW-1:0] REG_STATUS       = 4'h1;
  localparam logic [AW-1:0] REG_CUTTER_DIST  = 4'h2;
  localparam logic [AW-1:0] REG_SLOW_START   = 4'h3;
  localparam logic [AW-1:0] REG_CREEP_DIST   = 4'h4;
  localparam logic [AW-1:0] REG_SLOW_END     = 4'h5;
  localparam logic [AW-1:0] REG_MAX_SPEED    = 4'h6;
  localparam logic [AW-1:0] REG_ACCEL_RAMP   = 4'h7;
  localparam logic [AW-1:0] REG_DECEL_RAMP   = 4'h8;
  localparam logic [AW-1:0] REG_REVERSAL     = 4'h9;
  localparam logic [AW-1:0] REG_IDLE_TORQUE  = 4'hA;
  localparam logic [AW-1:0] REG_STATIC_FORCE = 4'hB;
  localparam logic [AW-1:0] REG_DOOR_WIDTH   = 4'hC;
  localparam logic [AW-1:0] REG_CYC_TARGET   = 4'hD;
  localparam logic [AW-1:0] REG_CYC_DONE     = 4'hE;

  // control register fields
  localparam int CTRL_CYC_EN       = 0;
  localparam int CTRL_TERM_VALID   = 1;
  localparam int CTRL_TERM_SPECIAL = 2;
  localparam int CTRL_TERM_CMD_LSB = 3;

  // command word fields: {special, command}
  localparam int WORD_SPECIAL = 3;

  // reset values
  localparam logic [DW-1:0] RST_CUTTER_DIST  = 16'h0020;
  localparam logic [DW-1:0] RST_SLOW_START   = 16'h0010;
  localparam logic [DW-1:0] RST_CREEP_DIST   = 16'h0040;
  localparam logic [DW-1:0] RST_SLOW_END     = 16'h0010;
  localparam logic [DW-1:0] RST_MAX_SPEED    = 16'h0100;
  localparam logic [DW-1:0] RST_ACCEL_RAMP   = 16'h0008;
  localparam logic [DW-1:0] RST_DECEL_RAMP   = 16'h0008;
  localparam logic [DW-1:0] RST_REVERSAL     = 16'h0010;
  localparam logic [DW-1:0] RST_IDLE_TORQUE  = 16'h0020;
  localparam logic [DW-1:0] RST_STATIC_FORCE = 16'h0200;
  localparam logic [DW-1:0] RST_DOOR_WIDTH   = 16'h1000;
  localparam logic [DW-1:0] RST_CYC_TARGET   = 16'h0000;

  // timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int TICK_PERIOD_US  = 1000;
  localparam int TICK_CYCLES     = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int RESPONSE_MAX_MS = 60;
  localparam int STANDSTILL_MS   = 500;
  localparam int STANDSTILL_TICKS = STANDSTILL_MS * 1000 / TICK_PERIOD_US;
  localparam int UNLOCK_MS       = 200;
  localparam int UNLOCK_TICKS    = UNLOCK_MS * 1000 / TICK_PERIOD_US;

  function automatic ddoa_cmd_t ddoa_word_cmd(input logic [2:0] f);
    return (f > CMD_STOP) ? CMD_NONE : ddoa_cmd_t'(f);
  endfunction

endpackage

// *** src/ddoa_prof_if.sv ***
// ddoa_prof_if: opening profile parameter snapshot and position toward the profile generator.
// assumes the main module owns the snapshot and the generator only reads it.
`timescale 1ns/1ps
interface ddoa_prof_if;
  import ddoa_pkg::*;
  logic [DW-1:0] cutterDist;
  logic [DW-1:0] slowStartSpd;
  logic [DW-1:0] creepDist;
  logic [DW-1:0] slowEndSpd;
  logic [DW-1:0] maxSpd;
  logic [DW-1:0] doorWidth;
  logic [DW-1:0] pos;
  logic [DW-1:0] target;
  modport owner (output cutterDist, slowStartSpd, creepDist, slowEndSpd, maxSpd, doorWidth, pos, input target);
  modport gen   (input cutterDist, slowStartSpd, creepDist, slowEndSpd, maxSpd, doorWidth, pos, output target);
endinterface
